// ===== hdl/wsc_core.sv
// Wake-up logic, sequencer, clock divider and ADC source control with AXI4-Lite registers
//
// Overview of operation
// - Mode field picks slave, timer or polling
// - Reset enters slave mode, pins rule
// - Polling cycles on/off in 31.25us ticks
// - Polling enables detect, 15us wake low pulse
// - One-shot valid pulse 2.6ms after on start
// - Continuous mode pulses every valid decision
// - Polling gates clock to on interval unless D9
// - Timer mode pulses wake after each period
// - Valid from RSSI and rate window
// - Data pin gated by enable, invert bits
// - Reset clock out is 1.06MHz default
// - Wake high at start extends clock
// - Clock stops in power-down unless D9 or polling on interval
// - Detect and transmit setup delays honoured
// - Test mode takes block power register
// - Output select picks clock source
// - Divide ratio is two times (code plus one)
// - Select bit routes ADC input
// - ADC result shows power-down and select
`timescale 1ns/1ps
`default_nettype none
module wsc_core
	import wsc_pkg::*;
#(
	parameter int DETECT_SETUP = wsc_pkg::DETECT_SETUP_CYC,
	parameter int CLOCK_SETUP = wsc_pkg::CLOCK_SETUP_CYC,
	parameter int TX_SETUP = 4000,
	parameter int RC_TICK = wsc_pkg::RC_TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Wake pin (open drain, active low pulse)
	input wire logic wake_pin_in,
	output logic wake_pin_out,
	output logic wake_pin_oe,
	// Control pins
	input wire logic receive_transmit_select_pin,
	input wire logic modulation_select_pin,
	// Data pin
	input wire logic rx_data,
	output logic data_pin_out,
	output logic data_pin_oe,
	// Clock sources and measurements
	input wire logic xtal_clk_en,
	input wire logic rc_clk_en,
	input wire wsc_pkg::wsc_meas_t meas,
	// Clock output and analog controls
	output logic clk_out,
	output logic [15:0] block_enable,
	output logic adc_select,
	output logic detect_enable,
	output logic pa_enable
);
	import wsc_pkg::*;

	logic [15:0] cfg;
	logic [7:0] on_time, off_time, adc_src_th, clk_div_reg;
	logic [11:0] lower_th, upper_th;
	logic [15:0] block_pwr;
	wsc_state_t state;
	logic [7:0] tick_cnt;
	logic [12:0] rc_cnt;
	logic rc_tick;
	logic [19:0] setup_cnt;
	logic [13:0] pulse_cnt;
	logic valid_q, setup_done, started, clk_ok, div_q;
	logic [4:0] div_cnt;
	logic [7:0] status_q;
	logic [7:0] adc_result;

	// Mode decode, used by several processes
	function automatic logic [1:0] mode_of(input logic [15:0] c);
		if (c[CFG_MODE_1])
			return 2'b10;
		return {1'b0, c[CFG_MODE_2]};
	endfunction
	wire logic polling = mode_of(cfg) == 2'b10;
	wire logic timer_mode = mode_of(cfg) == 2'b01;
	wire logic power_down = wake_pin_in;
	wire logic rx_active = !power_down && receive_transmit_select_pin;

	// Write channel: take address and data in either order
	logic aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire logic aw_now = aw_held || s_axi_awvalid;
	wire logic w_now = w_held || s_axi_wvalid;
	wire logic [11:0] wa = aw_held ? aw_addr : s_axi_awaddr;
	wire logic [31:0] wd = w_held ? w_data : s_axi_wdata;
	wire logic do_wr = aw_now && w_now && !s_axi_bvalid;
	wire logic [9:0] widx = wa[11:2];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready && !do_wr) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready && !do_wr) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (widx[7:0])
					IDX_CONFIG, IDX_ON_TIME, IDX_OFF_TIME, IDX_LOWER_TH, IDX_UPPER_TH,
					IDX_ADC_SRC_TH, IDX_CLK_DIV, IDX_BLOCK_PWR: begin
						s_axi_bresp <= (widx[9:8] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
					end
					default: begin
						s_axi_bresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register stores, low two byte lanes
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction
	wire logic wr_ok = do_wr && widx[9:8] == 2'b00;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= CFG_RESET;
			on_time <= ON_RESET;
			off_time <= OFF_RESET;
			lower_th <= 12'h000;
			upper_th <= 12'h000;
			adc_src_th <= ADC_SRC_RESET;
			clk_div_reg <= CLK_DIV_RESET;
			block_pwr <= BLOCK_PWR_RESET;
		end else if (wr_ok) begin
			case (widx[7:0])
				IDX_CONFIG: cfg <= merge(cfg, wd, s_axi_wstrb);
				IDX_ON_TIME: on_time <= s_axi_wstrb[0] ? wd[7:0] : on_time;
				IDX_OFF_TIME: off_time <= s_axi_wstrb[0] ? wd[7:0] : off_time;
				IDX_LOWER_TH: lower_th <= 12'(merge({4'h0, lower_th}, wd, s_axi_wstrb));
				IDX_UPPER_TH: upper_th <= 12'(merge({4'h0, upper_th}, wd, s_axi_wstrb));
				IDX_ADC_SRC_TH: adc_src_th <= s_axi_wstrb[0] ? wd[7:0] : adc_src_th;
				IDX_CLK_DIV: clk_div_reg <= s_axi_wstrb[0] ? (wd[7:0] & 8'h3f) : clk_div_reg;
				IDX_BLOCK_PWR: block_pwr <= merge(block_pwr, wd, s_axi_wstrb);
				default: cfg <= cfg;
			endcase
		end
	end

	// Read channel, one cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	wire logic [9:0] ridx = s_axi_araddr[11:2];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= (ridx[9:8] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
			case (ridx[7:0])
				IDX_CONFIG: s_axi_rdata <= {16'h0000, cfg};
				IDX_ON_TIME: s_axi_rdata <= {24'h000000, on_time};
				IDX_OFF_TIME: s_axi_rdata <= {24'h000000, off_time};
				IDX_LOWER_TH: s_axi_rdata <= {20'h00000, lower_th};
				IDX_UPPER_TH: s_axi_rdata <= {20'h00000, upper_th};
				IDX_ADC_SRC_TH: s_axi_rdata <= {24'h000000, adc_src_th};
				IDX_CLK_DIV: s_axi_rdata <= {24'h000000, clk_div_reg};
				IDX_BLOCK_PWR: s_axi_rdata <= {16'h0000, block_pwr};
				IDX_STATUS: s_axi_rdata <= {24'h000000, status_q};
				IDX_ADC_RESULT: s_axi_rdata <= {24'h000000, adc_result};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// 31.25us tick counted on clk, RC_TICK cycles per tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_cnt <= 13'h0000;
			rc_tick <= 1'b0;
		end else begin
			rc_tick <= rc_cnt == 13'(RC_TICK - 1);
			rc_cnt <= (rc_cnt == 13'(RC_TICK - 1)) ? 13'h0000 : rc_cnt + 13'h0001;
		end
	end

	// Interval state machine
	wire logic cycling = polling || timer_mode;
	// Counts the closing tick too, so a period is exactly on plus off ticks
	wire logic period_end = state == WSC_OFF && rc_tick && (tick_cnt + 8'h01 >= off_time);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= WSC_SLAVE;
			tick_cnt <= 8'h00;
		end else begin
			case (state)
				WSC_SLAVE: begin
					tick_cnt <= 8'h00;
					if (cycling && setup_done)
						state <= WSC_ON;
				end
				WSC_ON: begin
					if (!cycling) begin
						state <= WSC_SLAVE;
					end else if (rc_tick) begin
						tick_cnt <= tick_cnt + 8'h01;
						if (tick_cnt + 8'h01 >= on_time) begin
							state <= WSC_OFF;
							tick_cnt <= 8'h00;
						end
					end
				end
				WSC_OFF: begin
					if (!cycling) begin
						state <= WSC_SLAVE;
					end else if (rc_tick) begin
						tick_cnt <= tick_cnt + 8'h01;
						if (period_end) begin
							state <= (on_time == 8'h00) ? WSC_OFF : WSC_ON;
							tick_cnt <= 8'h00;
						end
					end
				end
				default: state <= WSC_SLAVE;
			endcase
		end
	end

	// Setup timing: system, detect and transmit delays share one counter
	wire logic on_start = state != WSC_ON || !rx_active;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_cnt <= 20'h00000;
			started <= 1'b0;
			setup_done <= 1'b0;
		end else begin
			if (!power_down)
				started <= 1'b1;
			if (!started || (power_down && !cycling) || (polling && on_start && state != WSC_ON))
				setup_cnt <= 20'h00000;
			else if (setup_cnt != 20'(DETECT_SETUP))
				setup_cnt <= setup_cnt + 20'h00001;
			if (started && setup_cnt == 20'(DETECT_SETUP))
				setup_done <= 1'b1;
		end
	end
	wire logic detect_ready = setup_cnt == 20'(DETECT_SETUP);
	assign detect_enable = cfg[CFG_TEST] ? !block_pwr[13] : (polling && state == WSC_ON && detect_ready) ||
		(!cycling && rx_active && detect_ready);
	assign pa_enable = cfg[CFG_TEST] ? !block_pwr[2] : (!power_down && !receive_transmit_select_pin &&
		setup_cnt >= 20'(TX_SETUP));
	assign block_enable = cfg[CFG_TEST] ? ~block_pwr : {16{!power_down || cycling}};

	// Data valid judgement
	wire logic [11:0] gc = meas.gate_count;
	wire logic rate_in = gc > lower_th && gc < upper_th;
	wire logic rate_half = gc > {1'b0, lower_th[11:1]} && gc < {1'b0, upper_th[11:1]};
	wire logic rssi_ok = meas.rssi_valid && meas.rssi > adc_src_th[5:0];
	wire logic data_valid = detect_enable && meas.win_done && rssi_ok && (rate_in || rate_half);
	logic fired;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fired <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= data_valid;
			if (state != WSC_ON)
				fired <= 1'b0;
			else if (data_valid && !cfg[CFG_ADC_CONT])
				fired <= 1'b1;
		end
	end
	wire logic cont = cfg[CFG_ADC_CONT] && cfg[CFG_WIN_CONT];
	wire logic valid_evt = polling && data_valid && !valid_q && (cont || !fired);
	wire logic timer_evt = timer_mode && period_end;

	// Wake pulse, 15us low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pulse_cnt <= 14'h0000;
		else if (valid_evt || timer_evt)
			pulse_cnt <= 14'(WAKE_PULSE_CYC);
		else if (pulse_cnt != 14'h0000)
			pulse_cnt <= pulse_cnt - 14'h0001;
	end
	assign wake_pin_out = 1'b0;
	assign wake_pin_oe = pulse_cnt != 14'h0000;

	// Data pin: ground unless enabled in receive; always ground in power-down
	assign data_pin_oe = 1'b1;
	assign data_pin_out = (cfg[CFG_DATA_OUT_EN] && rx_active) ? (rx_data ^ cfg[CFG_RX_INV]) : 1'b0;

	// Status and ADC feedback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= 8'h00;
			adc_result <= 8'h00;
		end else begin
			status_q <= {gc < lower_th, rate_in, gc > upper_th, gc < {1'b0, lower_th[11:1]}, rate_half,
				gc > {1'b0, upper_th[11:1]}, meas.rssi == adc_src_th[5:0], meas.rssi > adc_src_th[5:0]};
			if (meas.rssi_valid)
				adc_result <= {!block_enable[12], adc_select, meas.rssi};
		end
	end
	assign adc_select = adc_src_th[ADC_SELECT_BIT];

	// Clock divider: ratio 2*(code+1)
	wire logic [4:0] half = {1'b0, clk_div_reg[3:0]};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 5'h00;
			div_q <= 1'b0;
		end else if (xtal_clk_en) begin
			if (div_cnt >= half) begin
				div_cnt <= 5'h00;
				div_q <= !div_q;
			end else begin
				div_cnt <= div_cnt + 5'h01;
			end
		end
	end
	logic clk_src_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			clk_src_q <= 1'b0;
		else
			case (wsc_clk_src_t'(clk_div_reg[5:4]))
				WSC_SRC_DIV: clk_src_q <= div_q;
				WSC_SRC_XTAL: clk_src_q <= xtal_clk_en;
				WSC_SRC_RC: clk_src_q <= rc_clk_en;
				default: clk_src_q <= meas.win_done;
			endcase
	end
	// Clock runs before first activation and whenever awake; polling gates it by interval
	assign clk_ok = cfg[CFG_CLK_EN] || !started || !power_down ||
		(polling && state == WSC_ON);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			clk_out <= 1'b0;
		else
			clk_out <= clk_ok && clk_src_q;
	end

	// Guards
	sequence s_evt;
		valid_evt || timer_evt;
	endsequence
	AST_PULSE_LOW: assert property (@(posedge clk) disable iff (!rst_n) s_evt |=> wake_pin_oe [*8])
		else $error("wake pulse too short");
	AST_TIMER_PULSE: assert property (@(posedge clk) disable iff (!rst_n) timer_evt |=> wake_pin_oe)
		else $error("timer pulse missing");
	AST_SLAVE_RESET: assert property (@(posedge clk) disable iff (!rst_n) !cycling |=> state == WSC_SLAVE)
		else $error("left slave mode");
	AST_MODE_POLL: assert property (@(posedge clk) disable iff (!rst_n) cfg[CFG_MODE_1] |-> polling)
		else $error("mode decode");
	AST_DATA_GND: assert property (@(posedge clk) disable iff (!rst_n) power_down && !cfg[CFG_TEST] |-> !data_pin_out)
		else $error("data pin not grounded");
	AST_ADC_SEL: assert property (@(posedge clk) disable iff (!rst_n) $changed(adc_src_th) |-> adc_select == adc_src_th[6])
		else $error("adc select");
	AST_DETECT_SETUP: assert property (@(posedge clk) disable iff (!rst_n) detect_enable && !cfg[CFG_TEST] |-> detect_ready)
		else $error("detect before setup");
	AST_CLK_PD: assert property (@(posedge clk) disable iff (!rst_n) started && power_down && !cfg[CFG_CLK_EN] && !polling |=> !clk_out)
		else $error("clock in power down");
endmodule
`default_nettype wire

// ===== hdl/wsc_pkg.sv
// Package for the wake-up sequencer and clock control core
package wsc_pkg;
	// Register byte addresses (printed offsets are not all multiples of four: index * 4)
	localparam logic [7:0] IDX_CONFIG = 8'h00;
	localparam logic [7:0] IDX_ON_TIME = 8'h03;
	localparam logic [7:0] IDX_OFF_TIME = 8'h04;
	localparam logic [7:0] IDX_LOWER_TH = 8'h06;
	localparam logic [7:0] IDX_UPPER_TH = 8'h07;
	localparam logic [7:0] IDX_ADC_SRC_TH = 8'h08;
	localparam logic [7:0] IDX_CLK_DIV = 8'h0d;
	localparam logic [7:0] IDX_BLOCK_PWR = 8'h0f;
	localparam logic [7:0] IDX_STATUS = 8'h80;
	localparam logic [7:0] IDX_ADC_RESULT = 8'h81;
	// Config word fields
	localparam int CFG_ADC_CONT = 5;
	localparam int CFG_WIN_CONT = 6;
	localparam int CFG_CLK_EN = 9;
	localparam int CFG_DATA_OUT_EN = 10;
	localparam int CFG_RX_INV = 11;
	localparam int CFG_TEST = 12;
	localparam int CFG_MODE_2 = 13;
	localparam int CFG_MODE_1 = 14;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [7:0] ON_RESET = 8'hc0;
	localparam logic [7:0] OFF_RESET = 8'h80;
	localparam logic [7:0] ADC_SRC_RESET = 8'hff;
	localparam logic [7:0] CLK_DIV_RESET = 8'h08;
	localparam logic [15:0] BLOCK_PWR_RESET = 16'hffff;
	localparam int ADC_SELECT_BIT = 6;
	// Time figures and cycle counts at 250 MHz
	localparam int CLK_HZ = 250000000;
	localparam int RC_TICK_NS = 31250;
	localparam int WAKE_PULSE_NS = 15000;
	localparam int DETECT_SETUP_US = 2600;
	localparam int CLOCK_SETUP_US = 500;
	localparam int RC_TICK_CYC = RC_TICK_NS / 4;
	localparam int WAKE_PULSE_CYC = WAKE_PULSE_NS / 4;
	localparam int DETECT_SETUP_CYC = DETECT_SETUP_US * 250;
	localparam int CLOCK_SETUP_CYC = CLOCK_SETUP_US * 250;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Clock output sources
	typedef enum logic [1:0] {WSC_SRC_DIV = 2'b00, WSC_SRC_XTAL = 2'b01, WSC_SRC_RC = 2'b10,
		WSC_SRC_WIN = 2'b11} wsc_clk_src_t;
	typedef enum logic [1:0] {WSC_SLAVE = 2'b00, WSC_ON = 2'b01, WSC_OFF = 2'b11} wsc_state_t;
	typedef struct packed {
		logic [5:0] rssi;
		logic rssi_valid;
		logic win_done;
		logic [11:0] gate_count;
	} wsc_meas_t;
endpackage

// ===== verif/tb_top.sv
// Self-checking bench for the wake-up sequencer and clock control core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	import wsc_pkg::*;
	localparam int TICK = 8;
	logic clk, rst_n, act_req, rx_data, rtx_pin, rc_en;
	logic [1:0] prev_win, prev_rc;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wake_pin_in, wake_pin_out, wake_pin_oe, data_pin_out, data_pin_oe, clk_out;
	logic adc_select, detect_enable, pa_enable;
	logic [15:0] block_enable, last_width;
	logic [7:0] n_pulse;
	wsc_meas_t meas;
	int n_fail, compares, cyc;
	int seed = 32'h1f90;
	logic [31:0] rnd [4];
	logic [3:0] codes [5];
	localparam logic [7:0] RIDX [6] = '{8'h00, 8'h03, 8'h04, 8'h08, 8'h0d, 8'h0f};
	localparam logic [31:0] RVAL [6] = '{32'h0, 32'hc0, 32'h80, 32'hff, 32'h08, 32'hffff};

	wsc_core #(.DETECT_SETUP(50), .CLOCK_SETUP(20), .TX_SETUP(10), .RC_TICK(TICK)) DUT (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.wake_pin_in, .wake_pin_out, .wake_pin_oe, .receive_transmit_select_pin(rtx_pin),
		.modulation_select_pin(1'b0), .rx_data, .data_pin_out, .data_pin_oe, .xtal_clk_en(1'b1),
		.rc_clk_en(rc_en), .meas, .clk_out, .block_enable, .adc_select, .detect_enable, .pa_enable);
	wsc_mcu_model #(.HOLD(60)) MCU (.clk, .rst_n, .act_req, .wake_pin_oe, .wake_pin_in, .last_width, .n_pulse);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		prev_win <= {prev_win[0], meas.win_done};
		prev_rc <= {prev_rc[0], rc_en};
		meas <= 20'($random(seed));
		rc_en <= 1'($random(seed));
		rx_data <= ~rx_data;
	end

	function automatic int ratio(input logic [3:0] code);
		return 2 * (int'(code) + 1);
	endfunction
	function automatic int period(input int on, input int off);
		return (on + off) * TICK;
	endfunction

	task automatic axw(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
		logic a, w, b;
		int t;
		t = 0;
		b = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		r = 2'b00;
		while (!b && t < 200) begin
			@(posedge clk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			if (b) r = s_axi_bresp;
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			t++;
		end
		s_axi_bready <= 1'b0;
		if (!b) n_fail++;
	endtask
	task automatic axr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic a, b;
		int t;
		t = 0;
		b = 1'b0;
		@(posedge clk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		d = 32'h0;
		r = 2'b00;
		while (!b && t < 200) begin
			@(posedge clk);
			a = s_axi_arvalid && s_axi_arready;
			b = s_axi_rvalid && s_axi_rready;
			if (b) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
			if (a) s_axi_arvalid <= 1'b0;
			t++;
		end
		s_axi_rready <= 1'b0;
		if (!b) n_fail++;
	endtask
	// Counts rising edges of the clock output and the spacing of the last two
	task automatic rises(input int n, output int cnt, output int per);
		logic last;
		int t0;
		cnt = 0;
		per = 0;
		t0 = 0;
		@(negedge clk);
		last = clk_out;
		repeat (n) begin
			@(negedge clk);
			if (clk_out === 1'b1 && last === 1'b0) begin
				if (cnt > 0) per = cyc - t0;
				t0 = cyc;
				cnt++;
			end
			last = clk_out;
		end
	endtask
	task automatic wait_oe(input logic lvl, output int t);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (wake_pin_oe !== lvl && k < 20000);
		t = cyc;
		if (k >= 20000) n_fail++;
	endtask
	task automatic print_verdict;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		print_verdict;
	end

	initial begin
		int p, n, t0, t1;
		logic [31:0] d;
		logic [1:0] r;
		rst_n = 1'b0;
		act_req = 1'b0;
		rx_data = 1'b0;
		rtx_pin = 1'b1;
		rc_en = 1'b0;
		meas = '0;
		cyc = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		foreach (rnd[i]) rnd[i] = $random(seed);
		rnd[2][6] = 1'b0;
		rnd[3][6] = 1'b1;
		codes = '{4'h0, 4'hf, 4'h8, rnd[0][3:0], rnd[1][3:0]};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			axr(RIDX[i], d, r);
			`CHK(d, RVAL[i])
		end
		`CHK(adc_select, 1'b1)
		axr(8'h40, d, r);
		`CHK({r, d}, {RESP_SLVERR, 32'h0})
		axw(8'h41, 32'h1, r);
		`CHK(r, RESP_SLVERR)
		// Wake pin still high: clock offered before any activation
		foreach (codes[i]) begin
			axw(IDX_CLK_DIV, {28'h0, codes[i]}, r);
			rises(200, n, p);
			`CHK(p, ratio(codes[i]))
		end
		for (int s = 1; s < 4; s++) begin
			axw(IDX_CLK_DIV, {26'h0, 2'(s), 4'h8}, r);
			repeat (4) @(negedge clk);
			repeat (16) begin
				@(negedge clk);
				if (s == 1) `CHK(clk_out, 1'b1)
				else if (s == 2) `CHK(clk_out, prev_rc[1])
				else `CHK(clk_out, prev_win[1])
			end
		end
		for (int i = 2; i < 4; i++) begin
			axw(IDX_ADC_SRC_TH, {24'h0, rnd[i][7:0]}, r);
			@(negedge clk);
			`CHK(adc_select, rnd[i][6])
			axr(IDX_ADC_RESULT, d, r);
			`CHK(d[6], rnd[i][6])
		end
		// Activate, then let the pin float back to power-down
		axw(IDX_CLK_DIV, 32'h08, r);
		@(posedge clk);
		act_req <= 1'b1;
		@(posedge clk);
		act_req <= 1'b0;
		repeat (200) @(posedge clk);
		rises(100, n, p);
		`CHK(n, 0)
		`CHK(n_pulse, 8'h00)
		axw(IDX_CONFIG, 32'h1 << CFG_CLK_EN, r);
		rises(100, n, p);
		`CHK(n > 0, 1'b1)
		// Timer mode: on and off long enough that pulses never overlap
		axw(IDX_ON_TIME, 32'd240, r);
		axw(IDX_OFF_TIME, 32'd250, r);
		// Continuous detect bits as the controller would set them
		axw(IDX_CONFIG, (32'h1 << CFG_MODE_2) | (32'h1 << CFG_CLK_EN) | (32'h1 << CFG_ADC_CONT) | (32'h1 << CFG_WIN_CONT), r);
		wait_oe(1'b1, t0);
		wait_oe(1'b0, t1);
		wait_oe(1'b1, t1);
		`CHK(last_width, 16'(WAKE_PULSE_CYC))
		`CHK(t1 - t0, period(240, 250))
		`CHK(wake_pin_out, 1'b0)
		print_verdict;
	end
endmodule
`default_nettype wire

// ===== verif/wsc_mcu_model.sv
// Controller model on the wake pin: activation hold and pulse recording
`timescale 1ns/1ps
`default_nettype none
module wsc_mcu_model #(
	parameter int HOLD = 60
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench request and device pull-down
	input wire logic act_req,
	input wire logic wake_pin_oe,
	// Pin level and pulse record
	output logic wake_pin_in,
	output logic [15:0] last_width,
	output logic [7:0] n_pulse
);
	logic [15:0] hold_cnt;
	logic [15:0] width;
	// Pull-up wins only while nobody pulls the pin low
	assign wake_pin_in = !(wake_pin_oe || hold_cnt != 16'h0000);
	// Once asked, keep the device active for the whole setup time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= 16'h0000;
		end else if (act_req) begin
			hold_cnt <= 16'(HOLD);
		end else if (hold_cnt != 16'h0000) begin
			hold_cnt <= hold_cnt - 16'h0001;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			width <= 16'h0000;
			last_width <= 16'h0000;
			n_pulse <= 8'h00;
		end else if (wake_pin_oe) begin
			width <= width + 16'h0001;
		end else begin
			if (width != 16'h0000) begin
				last_width <= width;
				n_pulse <= n_pulse + 8'h01;
			end
			width <= 16'h0000;
		end
	end
endmodule
`default_nettype wire
